// ==== design/capture0_trigger_select_pkg.sv ====
// Package: register map, field positions and reset values of the capture 0 trigger select
package capture0_trigger_select_pkg;

  // ==========================================================================
  // Register bus
  // ==========================================================================
  localparam int          ADDR_W           = 4;
  localparam int          DATA_W           = 32;
  localparam logic [3:0]  CAP0_SEL_OFFSET  = 4'h0;   // Trigger source select register

  // ==========================================================================
  // Register contents
  // ==========================================================================
  localparam logic [31:0] CAP0_SEL_RESET   = 32'h0000_0000;
  localparam logic [31:0] CAP0_SEL_WMASK   = 32'hFF0F_FFFF; // Bits 23:20 held at reset value

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int          SOFT_TRIG_BIT    = 0;      // cap0_soft_trigger
  localparam int          UPDATE_BIT       = 1;      // cap0_on_update_event
  localparam int          EXT_LSB          = 2;      // cap0_on_ext_event_0
  localparam int          EXT_MSB          = 11;     // cap0_on_ext_event_9
  localparam int          EXT_COUNT        = 10;
  localparam int          SIB_COUNT        = 4;      // Siblings 0, 1, 3 and 4

  // Group base per sibling slot: rise, fall, compare 0, compare 1 in ascending order
  localparam int          SIB_BASE [SIB_COUNT] = '{12, 16, 24, 28};
  localparam int          OFS_RISE         = 0;
  localparam int          OFS_FALL         = 1;
  localparam int          OFS_CMP0         = 2;
  localparam int          OFS_CMP1         = 3;

endpackage

// ==== design/capture0_trigger_select.sv ====
// Module: capture 0 trigger source selection for one slave timer instance
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns

module capture0_trigger_select (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWriteData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regReadData,
  input  wire logic        updateEvent,
  input  wire logic [9:0]  extEvent,
  input  wire logic [3:0]  siblingCompare0,
  input  wire logic [3:0]  siblingCompare1,
  input  wire logic [3:0]  siblingChannel0Out,
  output logic             capture0Trigger
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0]  prevOut;
    logic        primed;
    logic        trigger;
    logic [31:0] readData;
  } state_t;

  state_t      cur;
  state_t      next_cur;

  logic        selHit;
  logic        softWrite;
  logic [3:0]  selRise;
  logic [3:0]  selFall;
  logic [3:0]  selCmp0;
  logic [3:0]  selCmp1;
  logic [3:0]  outRise;
  logic [3:0]  outFall;
  logic        anySource;

  // ==========================================================================
  // Field extraction
  // ==========================================================================
  // Per-sibling enables gathered from their scattered positions
  always_comb begin
    selRise = 4'h0;
    selFall = 4'h0;
    selCmp0 = 4'h0;
    selCmp1 = 4'h0;
    for (int i = 0; i < capture0_trigger_select_pkg::SIB_COUNT; i++) begin
      selRise[i] = cur.ctrl[capture0_trigger_select_pkg::SIB_BASE[i]
                            + capture0_trigger_select_pkg::OFS_RISE];
      selFall[i] = cur.ctrl[capture0_trigger_select_pkg::SIB_BASE[i]
                            + capture0_trigger_select_pkg::OFS_FALL];
      selCmp0[i] = cur.ctrl[capture0_trigger_select_pkg::SIB_BASE[i]
                            + capture0_trigger_select_pkg::OFS_CMP0];
      selCmp1[i] = cur.ctrl[capture0_trigger_select_pkg::SIB_BASE[i]
                            + capture0_trigger_select_pkg::OFS_CMP1];
    end
  end

  // Output transitions, suppressed until one sample of history exists
  assign outRise = (siblingChannel0Out & ~cur.prevOut) & {4{cur.primed}};
  assign outFall = (~siblingChannel0Out & cur.prevOut) & {4{cur.primed}};

  // Address decode
  assign selHit    = (regAddr == capture0_trigger_select_pkg::CAP0_SEL_OFFSET);
  assign softWrite = regWrite && selHit
                     && regWriteData[capture0_trigger_select_pkg::SOFT_TRIG_BIT];

  // ==========================================================================
  // Source combination
  // ==========================================================================
  // Any enabled source gives one capture request
  assign anySource =
      cur.ctrl[capture0_trigger_select_pkg::SOFT_TRIG_BIT]
    | (updateEvent && cur.ctrl[capture0_trigger_select_pkg::UPDATE_BIT])
    | (|(extEvent & cur.ctrl[capture0_trigger_select_pkg::EXT_MSB:
                             capture0_trigger_select_pkg::EXT_LSB]))
    | (|(siblingCompare0 & selCmp0))
    | (|(siblingCompare1 & selCmp1))
    | (|(outRise & selRise))
    | (|(outFall & selFall));

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_cur          = cur;
    next_cur.prevOut  = siblingChannel0Out;
    next_cur.primed   = 1'b1;
    next_cur.trigger  = anySource;
    next_cur.readData = 32'h0000_0000;
    // Soft trigger self-clears once it has been turned into a capture
    if (cur.ctrl[capture0_trigger_select_pkg::SOFT_TRIG_BIT]) begin
      next_cur.ctrl[capture0_trigger_select_pkg::SOFT_TRIG_BIT] = 1'b0;
    end
    // Register write; reserved bits keep their reset value
    if (regWrite && selHit) begin
      next_cur.ctrl = (regWriteData & capture0_trigger_select_pkg::CAP0_SEL_WMASK)
                    | (capture0_trigger_select_pkg::CAP0_SEL_RESET
                       & ~capture0_trigger_select_pkg::CAP0_SEL_WMASK);
      // A plain write of zero does not cancel a pending soft trigger
      if (cur.ctrl[capture0_trigger_select_pkg::SOFT_TRIG_BIT] && !softWrite) begin
        next_cur.ctrl[capture0_trigger_select_pkg::SOFT_TRIG_BIT] = 1'b0;
      end
    end
    // Register read; unmapped addresses answer zero
    if (regRead) begin
      if (selHit) begin
        next_cur.readData = cur.ctrl;
      end else begin
        next_cur.readData = 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur.ctrl     <= capture0_trigger_select_pkg::CAP0_SEL_RESET;
      cur.prevOut  <= 4'h0;
      cur.primed   <= 1'b0;
      cur.trigger  <= 1'b0;
      cur.readData <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  assign regReadData     = cur.readData;
  assign capture0Trigger = cur.trigger;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Soft trigger write fires two cycles later
  chk_soft_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    softWrite |-> ##2 capture0Trigger
  ) else $error("soft trigger write did not fire capture");

  // Soft trigger bit clears by itself
  chk_soft_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    softWrite ##1 !softWrite |=> !cur.ctrl[0]
  ) else $error("soft trigger bit did not self clear");

  // A pending soft trigger lasts one cycle unless written again
  chk_soft_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cur.ctrl[0] && !softWrite) |=> !cur.ctrl[0]
  ) else $error("soft trigger bit stayed set");

  // Enabled update event fires next cycle
  chk_update_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (updateEvent && cur.ctrl[1]) |=> capture0Trigger
  ) else $error("update event did not fire capture");

  // Enabled external events fire next cycle
  chk_ext_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (|(extEvent & cur.ctrl[11:2])) |=> capture0Trigger
  ) else $error("external event did not fire capture");

  // Enabled sibling compare 0 fires next cycle
  chk_cmp0_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (|(siblingCompare0 & {cur.ctrl[30], cur.ctrl[26], cur.ctrl[18], cur.ctrl[14]}))
      |=> capture0Trigger
  ) else $error("sibling compare 0 did not fire capture");

  // Enabled sibling compare 1 fires next cycle
  chk_cmp1_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (|(siblingCompare1 & {cur.ctrl[31], cur.ctrl[27], cur.ctrl[19], cur.ctrl[15]}))
      |=> capture0Trigger
  ) else $error("sibling compare 1 did not fire capture");

  // Enabled rising output fires next cycle
  chk_rise_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cur.primed && |(siblingChannel0Out & ~$past(siblingChannel0Out)
       & {cur.ctrl[28], cur.ctrl[24], cur.ctrl[16], cur.ctrl[12]})) |=> capture0Trigger
  ) else $error("output rise did not fire capture");

  // Enabled falling output fires next cycle
  chk_fall_fire: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cur.primed && |(~siblingChannel0Out & $past(siblingChannel0Out)
       & {cur.ctrl[29], cur.ctrl[25], cur.ctrl[17], cur.ctrl[13]})) |=> capture0Trigger
  ) else $error("output fall did not fire capture");

  // No capture without an enabled source the cycle before
  chk_no_spurious: assert property (
    @(posedge clk_sys) disable iff (rst)
    capture0Trigger |-> $past(cur.ctrl[0]
      || (updateEvent && cur.ctrl[1])
      || (|(extEvent & cur.ctrl[11:2]))
      || (|(siblingCompare0 & {cur.ctrl[30], cur.ctrl[26], cur.ctrl[18], cur.ctrl[14]}))
      || (|(siblingCompare1 & {cur.ctrl[31], cur.ctrl[27], cur.ctrl[19], cur.ctrl[15]}))
      || (cur.primed && |(siblingChannel0Out & ~cur.prevOut
           & {cur.ctrl[28], cur.ctrl[24], cur.ctrl[16], cur.ctrl[12]}))
      || (cur.primed && |(~siblingChannel0Out & cur.prevOut
           & {cur.ctrl[29], cur.ctrl[25], cur.ctrl[17], cur.ctrl[13]})))
  ) else $error("capture fired without enabled source");

endmodule  // capture0_trigger_select

// ==== bench/event_source_model.sv ====
// Behavioural model of the sibling timers and external event logic
`timescale 1ns/1ns

module event_source_model (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [18:0] pulseReq,
  input  wire logic [3:0]  levelReq,
  output logic             updateEvent,
  output logic      [9:0]  extEvent,
  output logic      [3:0]  siblingCompare0,
  output logic      [3:0]  siblingCompare1,
  output logic      [3:0]  siblingChannel0Out
);
  // One-cycle event pulses and held channel levels, launched after the edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {updateEvent, extEvent, siblingCompare0, siblingCompare1} <= '0;
      siblingChannel0Out <= 4'h0;
    end else begin
      {updateEvent, extEvent, siblingCompare0, siblingCompare1} <= pulseReq;
      siblingChannel0Out <= levelReq;
    end
  end
endmodule // event_source_model

// ==== bench/capture0_trigger_select_bench.sv ====
// Random self-checking testbench of the capture 0 trigger select
`timescale 1ns/1ns

module capture0_trigger_select_bench;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWriteData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [18:0] pulseReq = '0;
  logic [3:0]  levelReq = 4'h0;
  logic [31:0] regReadData, shadow, expRead;
  logic [9:0]  extEvent;
  logic [3:0]  siblingCompare0, siblingCompare1, siblingChannel0Out, prevOut;
  logic        updateEvent, capture0Trigger, expTrig, rdPend, histOk;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;

  capture0_trigger_select DUT (.clk_sys, .rst, .regAddr, .regWriteData, .regWrite, .regRead,
    .regReadData, .updateEvent, .extEvent, .siblingCompare0, .siblingCompare1,
    .siblingChannel0Out, .capture0Trigger);
  event_source_model PARTNER (.clk_sys, .rst, .pulseReq, .levelReq, .updateEvent, .extEvent,
    .siblingCompare0, .siblingCompare1, .siblingChannel0Out);

  // Clock of 10 ns period
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Expectation and checks
  // ==========================================================================
  // OR of all enabled sources, edges only once history exists
  function automatic logic trig(input logic [31:0] r);
    logic t;
    int   b;
    t = r[0] | (r[1] & updateEvent) | (|(r[11:2] & extEvent));
    for (int s = 0; s < 4; s++) begin
      b = capture0_trigger_select_pkg::SIB_BASE[s];
      t |= (r[b + 2] & siblingCompare0[s]) | (r[b + 3] & siblingCompare1[s]);
      t |= histOk & r[b] & siblingChannel0Out[s] & ~prevOut[s];
      t |= histOk & r[b + 1] & ~siblingChannel0Out[s] & prevOut[s];
    end
    return t;
  endfunction

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Shadow register and cycle by cycle comparison
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shadow = capture0_trigger_select_pkg::CAP0_SEL_RESET;
      {expTrig, rdPend, histOk, prevOut, expRead} = '0;
    end else begin
      cycles++;
      if (cycles > 5000) begin
        errors++;
        final_report();
      end
      compare({31'h0, capture0Trigger}, {31'h0, expTrig});
      compare(regReadData, rdPend ? expRead : 32'h0);
      expTrig = trig(shadow);
      rdPend = regRead;
      expRead = (regAddr == capture0_trigger_select_pkg::CAP0_SEL_OFFSET) ? shadow : 32'h0;
      if (regWrite && regAddr == capture0_trigger_select_pkg::CAP0_SEL_OFFSET) begin
        shadow = regWriteData & capture0_trigger_select_pkg::CAP0_SEL_WMASK;
      end else begin
        shadow[0] = 1'b0;
      end
      prevOut = siblingChannel0Out;
      histOk = 1'b1;
    end
  end

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  // One bus cycle plus one cycle of event requests
  task automatic step(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d,
                      input logic [18:0] p, input logic [3:0] l);
    regWrite <= w;
    regRead <= r && !w; // Never both strobes in one cycle
    regAddr <= a;
    regWriteData <= d & ~32'h00F0_0000;
    pulseReq <= p;
    levelReq <= l;
    @(posedge clk_sys);
  endtask

  initial begin
    void'($urandom(32'hFC8EF60D));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    step(0, 1, 4'h0, 0, 0, 0);
    // Each enable alone, then everything disabled
    for (int b = 0; b <= 32; b++) begin
      if (b < 20 || b > 23) begin
        step(1, 0, 4'h0, (b < 32) ? (32'h1 << b) : 32'h0, 0, 4'h0);
        step(0, 1, 4'h0, 0, '1, 4'hF);
        step(0, 0, 4'h0, 0, 0, 4'h0);
        step(0, 1, 4'h0, 0, '1, 4'h0);
      end
    end
    $display("single source sweep done");
    // Back to back soft trigger, clear while pending, unmapped access
    step(1, 0, 4'h0, 32'h1, 0, 0);
    step(1, 0, 4'h0, 32'h1, 0, 0);
    step(1, 0, 4'h0, 32'h0, 0, 0);
    step(1, 0, 4'h5, 32'hFFFF_FFFF, 0, 0);
    step(0, 1, 4'h5, 0, 0, 0);
    step(0, 1, 4'h0, 0, 0, 0);
    $display("soft trigger corners done");
    for (int i = 0; i < 3000; i++) begin
      step(($urandom % 8) == 0, ($urandom % 4) == 0 && (i % 8) != 0,
           (($urandom % 8) == 0) ? 4'($urandom) : 4'h0, $urandom,
           19'($urandom & $urandom & $urandom), 4'($urandom));
    end
    $display("random traffic done");
    // Reset in mid-run, then reset value read back
    rst <= 1'b1;
    step(0, 0, 4'h0, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 0);
    rst <= 1'b0;
    step(0, 1, 4'h0, 0, 0, 4'hF);
    step(0, 0, 4'h0, 0, 0, 0);
    step(0, 0, 4'h0, 0, 0, 0); // Last read check lands before the report
    $display("mid-run reset done");
    final_report();
  end
endmodule // capture0_trigger_select_bench
